// ### hw/rt_mode_map.vh
// constants for the remote-terminal mode-command handler
`ifndef RT_MODE_MAP_VH
`define RT_MODE_MAP_VH

// timing
`define CLK_PERIOD_NS 10
`define PULSE_NS 500
`define PULSE_CYCLES (`PULSE_NS / `CLK_PERIOD_NS)
`define PULSE_CNT_W 6

// command word fields
`define CMD_ADDR_HI 15
`define CMD_ADDR_LO 11
`define CMD_TR_BIT 10
`define CMD_SA_HI 9
`define CMD_SA_LO 5
`define CMD_MC_HI 4
`define CMD_MC_LO 0
`define BCAST_ADDR 5'h1f
`define SA_MODE0 5'h00
`define SA_MODE1 5'h1f

// mode codes
`define MC_SYNC 5'h01
`define MC_TX_STATUS 5'h02
`define MC_SELF_TEST 5'h03
`define MC_TX_SHUTDOWN 5'h04
`define MC_TX_OVERRIDE 5'h05
`define MC_TF_INHIBIT 5'h06
`define MC_TF_OVERRIDE 5'h07
`define MC_RESET_RT 5'h08

// register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS_WORD 12'h004
`define REG_MODE_STATE 12'h008
`define REG_IRQ_STATUS 12'h00c
`define REG_IRQ_MASK 12'h010
`define REG_HIGHWAY 12'h014

// control register fields
`define CTRL_ADDR_HI 4
`define CTRL_ADDR_LO 0
`define CTRL_ENABLE 5
`define CTRL_SREQ 8
`define CTRL_SSF 9
`define CTRL_BUSY 10
`define CTRL_TFLAG 11
`define CTRL_RESET 32'h0000_0000

// interrupt bits
`define IRQ_W 5
`define IRQ_STATUS_SENT 0
`define IRQ_TERMINATED 1
`define IRQ_SYNC 2
`define IRQ_BCAST 3
`define IRQ_RESET_RT 4

// mode state fields
`define MS_SHUTDOWN 0
`define MS_TF_INHIBIT 1
`define MS_SYNC_ACTIVE 2
`define MS_RESET_ACTIVE 3

`endif

// ### hw/pulse_timer.v
// fixed-length active-low pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "rt_mode_map.vh"

module pulse_timer
(
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire start, // one-cycle start request
  output reg pulse_n_q // low for the pulse length
);

  reg [`PULSE_CNT_W-1:0] cnt_q; // cycles still to run
  localparam integer LEN_I = `PULSE_CYCLES; // full pulse length in cycles
  // cut to the counter width on purpose; the count always fits
  localparam [`PULSE_CNT_W-1:0] LEN = LEN_I[`PULSE_CNT_W-1:0];

  // a restart while running stretches the pulse to a full length again
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= {`PULSE_CNT_W{1'b0}};
      pulse_n_q <= 1'b1;
    end
    else if (start)
    begin
      cnt_q <= LEN - 6'h01;
      pulse_n_q <= 1'b0;
    end
    else if (cnt_q != {`PULSE_CNT_W{1'b0}})
    begin
      cnt_q <= cnt_q - 6'h01;
    end
    else
    begin
      pulse_n_q <= 1'b1;
    end
  end

endmodule // pulse_timer
`default_nettype wire

// ### hw/rt_mode_code_handler.v
// remote-terminal mode-command handler with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "rt_mode_map.vh"

module rt_mode_code_handler
(
  input wire pclk, // system clock, 100 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, 1 = write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire cmd_strobe, // one-cycle pulse: command word decoded
  input wire cmd_ok, // command word had good sync and parity
  input wire [15:0] cmd_word, // decoded command word
  input wire word_strobe, // one-cycle pulse: any non-command word seen
  input wire gap_done, // one-cycle pulse: bus quiet, answer now
  input wire [15:0] subsystem_highway_in, // highway level seen at the pins
  output reg [15:0] subsystem_highway_out, // highway drive value
  output reg subsystem_highway_oe, // high while driving the highway
  output reg sync_pulse_n, // sync pulse to subsystem, active low
  output reg subsystem_reset_n, // reset pulse to subsystem, active low
  output reg command_strobe_n, // transfer strobe, never active here
  output reg status_tx_req, // one-cycle pulse: send status_tx_word
  output reg [15:0] status_tx_word, // status word to transmit
  output reg alt_tx_shutdown, // high while alternate transmitter is off
  output reg irq // level interrupt
);

  localparam [0:0] ST_IDLE = 1'b0; // waiting for a mode command
  localparam [0:0] ST_WAIT = 1'b1; // command held, watching for extra words

  reg [0:0] state_q; // sequencer state
  reg [15:0] cmd_q; // accepted command word
  reg [31:0] ctrl_q; // control register
  reg me_q; // message error status bit
  reg bcst_q; // broadcast received status bit
  reg tf_q; // latched terminal flag status bit
  reg tf_inhibit_q; // terminal flag blocked
  reg [`IRQ_W-1:0] irq_stat_q; // sticky event bits
  reg [`IRQ_W-1:0] irq_mask_q; // event enables
  reg [`IRQ_W-1:0] irq_set; // events this cycle
  reg sync_start; // start sync pulse timer
  reg reset_start; // start reset pulse timer
  wire sync_n; // sync timer output
  wire rst_n; // reset timer output
  wire [15:0] status_now; // status word as it stands

  // true for a command word that this handler owns
  function handled;
    input [15:0] w;
    input [4:0] own;
    reg addr_ok;
    reg sa_ok;
    reg mc_ok;
    begin
      addr_ok = (w[`CMD_ADDR_HI:`CMD_ADDR_LO] == own)
        || (w[`CMD_ADDR_HI:`CMD_ADDR_LO] == `BCAST_ADDR);
      sa_ok = (w[`CMD_SA_HI:`CMD_SA_LO] == `SA_MODE0)
        || (w[`CMD_SA_HI:`CMD_SA_LO] == `SA_MODE1);
      mc_ok = (w[`CMD_MC_HI:`CMD_MC_LO] >= `MC_SYNC)
        && (w[`CMD_MC_HI:`CMD_MC_LO] <= `MC_RESET_RT);
      handled = addr_ok && sa_ok && mc_ok;
    end
  endfunction

  // true when the command went to the broadcast address
  function is_bcast;
    input [15:0] w;
    begin
      is_bcast = (w[`CMD_ADDR_HI:`CMD_ADDR_LO] == `BCAST_ADDR);
    end
  endfunction

  wire [4:0] mc = cmd_q[`CMD_MC_HI:`CMD_MC_LO]; // held mode code
  wire bc = is_bcast(cmd_q); // held broadcast flag
  wire enabled = ctrl_q[`CTRL_ENABLE]; // terminal on line
  // invalid words never start a sequence
  wire take_cmd = cmd_strobe && cmd_ok && enabled
    && handled(cmd_word, ctrl_q[`CTRL_ADDR_HI:`CTRL_ADDR_LO]);

  // status word assembled from held bits and live subsystem bits
  assign status_now = {ctrl_q[`CTRL_ADDR_HI:`CTRL_ADDR_LO], me_q, 1'b0,
    ctrl_q[`CTRL_SREQ], 3'b000, bcst_q, ctrl_q[`CTRL_BUSY],
    ctrl_q[`CTRL_SSF], 1'b0, tf_q};

  // apb decode
  wire setup = psel && !penable; // first cycle of a transfer
  wire wr_done = psel && penable && pready && pwrite; // write takes effect
  wire addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS_WORD)
    || (paddr == `REG_MODE_STATE) || (paddr == `REG_IRQ_STATUS)
    || (paddr == `REG_IRQ_MASK) || (paddr == `REG_HIGHWAY);

  // apb slave: data prepared in setup, ready in the one access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      if (setup && !pwrite)
      begin
        if (paddr == `REG_CTRL)
          prdata <= ctrl_q;
        else if (paddr == `REG_STATUS_WORD)
          prdata <= {16'h0000, status_now};
        else if (paddr == `REG_MODE_STATE)
          prdata <= {28'h0000000, !rst_n, !sync_n, tf_inhibit_q, alt_tx_shutdown};
        else if (paddr == `REG_IRQ_STATUS)
          prdata <= {27'h0000000, irq_stat_q};
        else if (paddr == `REG_IRQ_MASK)
          prdata <= {27'h0000000, irq_mask_q};
        else if (paddr == `REG_HIGHWAY)
          prdata <= {16'h0000, subsystem_highway_in};
        else
          prdata <= 32'h0000_0000; // unmapped reads zero, with error
      end
    end
  end

  // software registers: control and mask; status clears are below
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `CTRL_RESET;
      irq_mask_q <= {`IRQ_W{1'b0}};
    end
    else if (wr_done)
    begin
      if (paddr == `REG_CTRL)
        ctrl_q <= {20'h00000, pwdata[11:8], 2'b00, pwdata[5:0]};
      else if (paddr == `REG_IRQ_MASK)
        irq_mask_q <= pwdata[`IRQ_W-1:0];
    end
  end

  // sequencer: accepts a command, then waits for the bus gap to decide
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      cmd_q <= 16'h0000;
    end
    else if (take_cmd)
    begin
      // a newer valid command replaces any held one
      state_q <= ST_WAIT;
      cmd_q <= cmd_word;
    end
    else if (state_q == ST_WAIT && (word_strobe || gap_done))
    begin
      state_q <= ST_IDLE;
    end
  end

  // decision made at the end of the wait; one pass, no strobe ever
  always @*
  begin
    irq_set = {`IRQ_W{1'b0}};
    sync_start = 1'b0;
    reset_start = 1'b0;
    if (state_q == ST_WAIT && !take_cmd)
    begin
      if (word_strobe)
        irq_set[`IRQ_TERMINATED] = 1'b1;
      else if (gap_done)
      begin
        if (!cmd_q[`CMD_TR_BIT] || (mc == `MC_TX_STATUS && bc))
          irq_set[`IRQ_TERMINATED] = 1'b1;
        else
        begin
          irq_set[`IRQ_STATUS_SENT] = !bc;
          irq_set[`IRQ_BCAST] = bc;
          sync_start = (mc == `MC_SYNC);
          reset_start = (mc == `MC_RESET_RT);
          irq_set[`IRQ_SYNC] = (mc == `MC_SYNC);
          irq_set[`IRQ_RESET_RT] = (mc == `MC_RESET_RT);
        end
      end
    end
  end

  // status bits: loaded on a new command except transmit status
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      me_q <= 1'b0;
      bcst_q <= 1'b0;
      tf_q <= 1'b0;
    end
    else if (take_cmd)
    begin
      if (cmd_word[`CMD_MC_HI:`CMD_MC_LO] != `MC_TX_STATUS)
      begin
        // fresh status for this command, terminal flag only if allowed
        me_q <= 1'b0;
        bcst_q <= 1'b0;
        tf_q <= ctrl_q[`CTRL_TFLAG] && !tf_inhibit_q;
      end
      // transmit status leaves the previous result untouched
    end
    else if (irq_set[`IRQ_TERMINATED])
    begin
      me_q <= 1'b1;
      bcst_q <= bc;
    end
    else if (irq_set[`IRQ_BCAST])
    begin
      bcst_q <= 1'b1;
    end
  end

  // status transmit request; transmit status sends status_now with the status bits left by the last command
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_tx_req <= 1'b0;
      status_tx_word <= 16'h0000;
    end
    else
    begin
      status_tx_req <= irq_set[`IRQ_STATUS_SENT];
      if (irq_set[`IRQ_STATUS_SENT])
        status_tx_word <= status_now;
    end
  end

  // alternate transmitter and flag inhibit, changed with the status request, or at the gap for a broadcast
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alt_tx_shutdown <= 1'b0;
      tf_inhibit_q <= 1'b0;
    end
    else if (irq_set[`IRQ_STATUS_SENT] || irq_set[`IRQ_BCAST])
    begin
      if (mc == `MC_TX_SHUTDOWN)
        alt_tx_shutdown <= 1'b1;
      else if (mc == `MC_TX_OVERRIDE)
        alt_tx_shutdown <= 1'b0;
      else if (mc == `MC_TF_INHIBIT)
        tf_inhibit_q <= 1'b1;
      else if (mc == `MC_TF_OVERRIDE)
        tf_inhibit_q <= 1'b0;
      else if (mc == `MC_RESET_RT)
      begin
        alt_tx_shutdown <= 1'b0;
        tf_inhibit_q <= 1'b0;
      end
    end
  end

  // highway forced to zero from sync until the next command word with good sync and parity
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      subsystem_highway_oe <= 1'b0;
      subsystem_highway_out <= 16'h0000;
    end
    else if (cmd_strobe && cmd_ok)
      subsystem_highway_oe <= 1'b0;
    else if (sync_start)
    begin
      subsystem_highway_oe <= 1'b1;
      subsystem_highway_out <= 16'h0000;
    end
  end

  // pulse timers for sync and subsystem reset
  pulse_timer u_sync_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(sync_start),
    .pulse_n_q(sync_n)
  );

  pulse_timer u_reset_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(reset_start),
    .pulse_n_q(rst_n)
  );

  // retimed pin copies; one cycle later than the timers, same length
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_pulse_n <= 1'b1;
      subsystem_reset_n <= 1'b1;
      command_strobe_n <= 1'b1;
    end
    else
    begin
      sync_pulse_n <= sync_n;
      subsystem_reset_n <= rst_n;
      command_strobe_n <= 1'b1;
    end
  end

  // sticky events: a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (wr_done && paddr == `REG_IRQ_STATUS)
        irq_stat_q <= (irq_stat_q & ~pwdata[`IRQ_W-1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // rt_mode_code_handler
`default_nettype wire

// ### test/bc_model.sv
// bus-side command source model for the mode-command handler
`timescale 1ns/1ps
`default_nettype none
module bc_model
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic go, // send one command
  input wire logic [15:0] w, // command word to send
  input wire logic ok, // word arrives good
  input wire logic extra, // follow with a data word
  output logic cmd_strobe, // word decoded
  output logic cmd_ok, // word good
  output logic [15:0] cmd_word, // decoded word
  output logic word_strobe, // extra word seen
  output logic gap_done // bus gap
);
  logic sent_q; // command out, gap or word due next
  // outside its strobe the word and ok flag are inverted every cycle, so a stale value never holds still
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {cmd_strobe, cmd_ok, word_strobe, gap_done, sent_q} <= 5'h0;
      cmd_word <= 16'h0;
    end
    else
    begin
      cmd_strobe <= go;
      sent_q <= go;
      cmd_word <= go ? w : ~cmd_word;
      cmd_ok <= go ? ok : ~cmd_ok;
      word_strobe <= sent_q & extra; // contiguous word breaks the sequence
      gap_done <= sent_q & ~extra; // quiet bus, answer due
    end
endmodule // bc_model
`default_nettype wire

// ### test/rt_mode_code_handler_asserts.sv
// port assertions for the mode-command handler
`timescale 1ns/1ps
`default_nettype none
module rt_mode_checker
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic word_strobe, // extra word
  input wire logic gap_done, // bus gap
  input wire logic [15:0] subsystem_highway_out, // highway value
  input wire logic subsystem_highway_oe, // highway enable
  input wire logic sync_pulse_n, // sync pulse
  input wire logic subsystem_reset_n, // subsystem reset pulse
  input wire logic command_strobe_n, // transfer strobe
  input wire logic status_tx_req // status request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0] low_q; // sync low cycles so far
  // a counter, since 50 cycles is too long to unroll as a repetition
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_q <= 7'h0;
    else
      low_q <= sync_pulse_n ? 7'h0 : low_q + 7'h1;
  a_sync_length: assert property ($rose(sync_pulse_n) |-> low_q == 7'h32)
    else $error("sync pulse length wrong");
  a_highway_zero: assert property (subsystem_highway_oe |-> subsystem_highway_out == 16'h0)
    else $error("highway not zero while driven");
  a_sync_zeroes: assert property (!sync_pulse_n |-> subsystem_highway_oe)
    else $error("highway released during sync");
  a_no_strobe: assert property (command_strobe_n)
    else $error("command strobe went active");
  a_req_single: assert property (status_tx_req |=> !status_tx_req)
    else $error("status request longer than one cycle");
  a_req_cause: assert property (status_tx_req |-> $past(gap_done) && !$past(word_strobe))
    else $error("status request without quiet gap");
  a_reset_pulse: assert property ($fell(subsystem_reset_n) |-> !subsystem_reset_n [*8])
    else $error("subsystem reset pulse too short");
  a_ready_after: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // rt_mode_checker
bind rt_mode_code_handler rt_mode_checker u_chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .word_strobe, .gap_done, .subsystem_highway_out, .subsystem_highway_oe,
  .sync_pulse_n, .subsystem_reset_n, .command_strobe_n, .status_tx_req);
`default_nettype wire

// ### test/test_rt_mode_code_handler.sv
// self-checking bench for the mode-command handler
`timescale 1ns/1ps
`default_nettype none
module test_rt_mode_code_handler;
  logic pclk = 1'b0, presetn = 1'b0; // clock and reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [11:0] paddr = 12'h0; // apb address
  logic [31:0] pwdata = 32'h0, prdata; // apb data
  logic pready, pslverr, cs, cok, ws, gd, oe, sn, rn, csn, req, shut, irq; // handshakes
  logic [15:0] cw, hw_in = 16'h0, hw_out, txw; // words
  logic go = 1'b0, mok = 1'b0, mx = 1'b0; // model controls
  logic [15:0] mw = 16'h0; // word for the model
  logic [31:0] exp_q[$]; // expected status words, mask over value
  logic [31:0] note; // oldest expectation, taken off the queue
  int errors = 0, tests_run = 0; // counters
  rt_mode_code_handler dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_strobe(cs), .cmd_ok(cok), .cmd_word(cw), .word_strobe(ws),
    .gap_done(gd), .subsystem_highway_in(hw_in), .subsystem_highway_out(hw_out),
    .subsystem_highway_oe(oe), .sync_pulse_n(sn), .subsystem_reset_n(rn),
    .command_strobe_n(csn), .status_tx_req(req), .status_tx_word(txw),
    .alt_tx_shutdown(shut), .irq(irq));
  bc_model bc_u (.pclk(pclk), .presetn(presetn), .go(go), .w(mw), .ok(mok), .extra(mx),
    .cmd_strobe(cs), .cmd_ok(cok), .cmd_word(cw), .word_strobe(ws), .gap_done(gd));
  initial forever #5 pclk = ~pclk;
  // 33 bits so that the error flag of a read is compared too
  task check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; holds the request until ready is sampled high
  // no cycle count is assumed here: only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, e);
  endtask
  // random sub-address, both mode forms
  function automatic logic [15:0] mk(input logic [4:0] a, input logic t, input logic [4:0] m);
    mk = {a, t, ($urandom_range(1) ? 5'h1f : 5'h00), m};
  endfunction
  task send(input logic [15:0] w, input logic k, input logic x, input int n);
    @(posedge pclk);
    {go, mw, mok, mx} <= {1'b1, w, k, x};
    @(posedge pclk);
    go <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task ex(input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v});
  endtask
  // each status request takes the oldest expectation; none left means an unwanted answer
  always @(posedge pclk)
    if (req === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        note = exp_q.pop_front();
        check(txw & note[31:16], note[15:0]);
      end
    end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial
  begin
    #200us;
    errors++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(64));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    hw_in <= $urandom;
    wr(12'h000, 32'h825);
    rd(12'h000, 33'h825);
    rd(12'h020, 33'h100000000);
    rd(12'h014, {17'h0, hw_in});
    ex(16'hffff, 16'h2801);
    send(mk(5'h05, 1, 5'h01), 1, 0, 10);
    check(sn, 0);
    repeat (50) @(posedge pclk);
    check({sn, oe}, 2'b11);
    send(mk(5'h05, 0, 5'h03), 1, 0, 6);
    check(oe, 0);
    rd(12'h004, 33'h2c01);
    ex(16'hffff, 16'h2c01);
    send(mk(5'h05, 1, 5'h02), 1, 0, 6);
    send(mk(5'h1f, 1, 5'h04), 1, 0, 6);
    check(shut, 1);
    rd(12'h004, 33'h2811);
    send(mk(5'h05, 1, 5'h05), 0, 0, 6);
    check(shut, 1);
    rd(12'h004, 33'h2811);
    ex(16'hffff, 16'h2801);
    send(mk(5'h05, 1, 5'h03), 1, 0, 6);
    check(shut, 1);
    ex(16'hffff, 16'h2801);
    send(mk(5'h05, 1, 5'h05), 1, 0, 6);
    check(shut, 0);
    send(mk(5'h05, 1, 5'h01), 1, 1, 10);
    check(sn, 1);
    rd(12'h004, 33'h2c01);
    send(mk(5'h1f, 1, 5'h02), 1, 0, 6);
    rd(12'h004, 33'h2c11);
    send(mk(5'h1f, 0, 5'h06), 1, 0, 6);
    rd(12'h004, 33'h2c11);
    ex(16'hfffe, 16'h2800);
    send(mk(5'h05, 1, 5'h06), 1, 0, 6);
    ex(16'hffff, 16'h2800);
    send(mk(5'h05, 1, 5'h03), 1, 0, 6);
    ex(16'hfffe, 16'h2800);
    send(mk(5'h05, 1, 5'h07), 1, 0, 6);
    ex(16'hffff, 16'h2801);
    send(mk(5'h05, 1, 5'h03), 1, 0, 6);
    ex(16'hfffe, 16'h2800);
    send(mk(5'h05, 1, 5'h06), 1, 0, 6);
    ex(16'hfffe, 16'h2800);
    send(mk(5'h05, 1, 5'h04), 1, 0, 6);
    ex(16'hffff, 16'h2800);
    send(mk(5'h05, 1, 5'h05), 1, 0, 6);
    ex(16'hfffe, 16'h2800);
    send(mk(5'h05, 1, 5'h04), 1, 0, 6);
    ex(16'hfffe, 16'h2800);
    send(mk(5'h05, 1, 5'h08), 1, 0, 10);
    check(rn, 0);
    repeat (50) @(posedge pclk);
    check(shut, 0);
    rd(12'h008, 33'h0);
    wr(12'h010, 32'h1);
    repeat (3) @(posedge pclk);
    check(irq, 1);
    wr(12'h00c, 32'h1f);
    repeat (3) @(posedge pclk);
    check(irq, 0);
    ex(16'hffff, 16'h2801);
    send(mk(5'h05, 1, 5'h03), 1, 0, 6);
    check(irq, 1);
    rd(12'h00c, 33'h1);
    wr(12'h010, 32'h0);
    repeat (3) @(posedge pclk);
    check(irq, 0);
    check(exp_q.size(), 0);
    print_verdict();
  end
endmodule // test_rt_mode_code_handler
`default_nettype wire
